// >>> omm_consts.vh
`ifndef OMM_CONSTS_VH
`define OMM_CONSTS_VH
// core clock rate
`define OMM_CLK_HZ 36'd100000000
`define OMM_CLK_MHZ 36'd100
// shutdown hold time for a transmitter reset, in us (least time, rounds up)
`define OMM_TRESET_US 36'd10
`define OMM_TRESET_CYCLES ((`OMM_TRESET_US * `OMM_CLK_MHZ))
// longest time to turn the transmitter off, in us; logic acts in 3 cycles
`define OMM_TOFF_US 36'd10
// longest time to resume after shutdown release, in us; logic acts in 3 cycles
`define OMM_TON_US 36'd1000
// initialisation window, in s
`define OMM_TINIT_S 36'd90
`define OMM_INIT_CYCLES (`OMM_TINIT_S * `OMM_CLK_HZ)
// serial port defaults
`define OMM_DEV_ADDR 7'h50
`define OMM_MEM_AW 4
// status byte bit positions, read at pointer 0
`define OMM_ST_FAULT 0
`define OMM_ST_TXOFF 1
`define OMM_ST_INIT 2
`define OMM_ST_SHDN 3
`endif

// >>> omm_sync.v
`timescale 1ns/10ps
`default_nettype none
module omm_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk,
  input wire arst_n,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;
  // two-flop synchroniser, stage1 feeds only syncOut
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> omm_mgmt_port.v
`timescale 1ns/10ps
`default_nettype none
`include "omm_consts.vh"
// Functional notes
// - serial port works at 100kHz and 400kHz clock rates.
// - bus is idle whenever data and clock both sample high.
// - data stable while clock high; changes then are control conditions.
// - data falling while clock high is START; module detects it.
// - data rising while clock high is STOP; ends the transaction.
// - after STOP, enter low-power idle until next START.
// - one clock pulse per bit; bit valid during high period.
// - module pulls data low in ninth pulse to acknowledge a matching address and each written byte.
// - shutdown input high turns transmitter off; low transmits once initialisation is over and no fault is present or latched.
// - off within 10 us of shutdown high; on within 1 ms of low.
// - initialisation up to 90 s; fault shown meanwhile is tolerated.
// - fault output low in normal operation, high on fault and during initialisation.
// - presence line tied low internally.
module omm_mgmt_port #(
  parameter [6:0] DEV_ADDR = `OMM_DEV_ADDR,
  parameter AW = `OMM_MEM_AW,
  parameter [35:0] INIT_CYCLES = `OMM_INIT_CYCLES
) (
  input wire core_clk,
  input wire arst_n,
  input wire serialClockLine,
  input wire serialDataLineIn,
  output reg serialDataLineOut,
  output reg serialDataLineOe,
  input wire txShutdown,
  input wire txFaultCause,
  output reg txFault,
  output reg txEnable,
  output reg modulePresenceLine,
  output reg busIdle,
  output reg lowPower
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_ACKA = 7'h04;
  localparam [6:0] S_WR = 7'h08;
  localparam [6:0] S_ACKW = 7'h10;
  localparam [6:0] S_RD = 7'h20;
  localparam [6:0] S_RACK = 7'h40;
  localparam DEPTH = 1 << AW;
  localparam [35:0] RESET_CYC_FULL = `OMM_TRESET_CYCLES;
  localparam [10:0] RESET_CYC = RESET_CYC_FULL[10:0];

  wire [3:0] syncQ;
  wire scl = syncQ[0];
  wire sda = syncQ[1];
  wire sdn = syncQ[2];
  wire faultCause = syncQ[3];
  reg sclPrev;
  reg sdaPrev;
  reg sdnPrev;
  reg [6:0] state;
  reg [3:0] bitCnt;
  reg [7:0] rxShift;
  reg [7:0] txShift;
  reg readDir;
  reg firstByte;
  reg [AW-1:0] ptr;
  reg [7:0] mem [0:DEPTH-1];
  reg [35:0] initCnt;
  reg initBusy;
  reg [10:0] sdnCnt;
  reg resetMet;
  reg faultLatched;
  reg [7:0] readByte;
  integer i;

  // pins pass two flops before any logic; 100 MHz sampling covers both rates
  omm_sync #(.WIDTH(4)) i_omm_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .asyncIn({txFaultCause, txShutdown, serialDataLineIn, serialClockLine}),
    .syncOut(syncQ)
  );

  wire sclRise = scl & ~sclPrev;
  wire sclFall = ~scl & sclPrev;
  wire startCond = scl & sclPrev & sdaPrev & ~sda;
  wire stopCond = scl & sclPrev & ~sdaPrev & sda;
  wire [7:0] nextRx = {rxShift[6:0], sda};

  // status byte stands at pointer 0, the rest is scratch storage
  always @* begin
    readByte = mem[ptr];
    if (ptr == {AW{1'b0}}) begin
      readByte = 8'h00;
      readByte[`OMM_ST_FAULT] = faultLatched;
      readByte[`OMM_ST_TXOFF] = ~txEnable;
      readByte[`OMM_ST_INIT] = initBusy;
      readByte[`OMM_ST_SHDN] = sdn;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      state <= S_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h00;
      txShift <= 8'h00;
      readDir <= 1'b0;
      firstByte <= 1'b0;
      ptr <= {AW{1'b0}};
      serialDataLineOut <= 1'b0;
      serialDataLineOe <= 1'b0;
      busIdle <= 1'b1;
      lowPower <= 1'b1;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 8'h00;
      end
    end else begin
      sclPrev <= scl;
      sdaPrev <= sda;
      serialDataLineOut <= 1'b0;
      busIdle <= scl & sda;
      if (startCond) begin
        state <= S_ADDR;
        bitCnt <= 4'h0;
        serialDataLineOe <= 1'b0;
        lowPower <= 1'b0;
      end else if (stopCond) begin
        state <= S_IDLE;
        serialDataLineOe <= 1'b0;
        lowPower <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            serialDataLineOe <= 1'b0;
          end
          S_ADDR, S_WR: begin
            if (sclRise) begin
              rxShift <= nextRx;
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              if (state == S_ADDR) begin
                if (rxShift[7:1] == DEV_ADDR) begin
                  readDir <= rxShift[0];
                  firstByte <= 1'b1;
                  serialDataLineOe <= 1'b1;
                  state <= S_ACKA;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                serialDataLineOe <= 1'b1;
                state <= S_ACKW;
                firstByte <= 1'b0;
                if (firstByte) begin
                  ptr <= rxShift[AW-1:0];
                end else begin
                  if (ptr != {AW{1'b0}}) begin
                    mem[ptr] <= rxShift;
                  end
                  ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
                end
              end
            end
          end
          S_ACKA, S_ACKW: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (state == S_ACKA && readDir) begin
                txShift <= {readByte[6:0], 1'b0};
                serialDataLineOe <= ~readByte[7];
                state <= S_RD;
              end else begin
                serialDataLineOe <= 1'b0;
                state <= S_WR;
              end
            end
          end
          S_RD: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall) begin
              if (bitCnt == 4'h8) begin
                serialDataLineOe <= 1'b0;
                ptr <= ptr + {{(AW-1){1'b0}}, 1'b1};
                state <= S_RACK;
              end else begin
                serialDataLineOe <= ~txShift[7];
                txShift <= {txShift[6:0], 1'b0};
              end
            end
          end
          S_RACK: begin
            if (sclRise && sda) begin
              state <= S_IDLE;
            end else if (sclFall) begin
              bitCnt <= 4'h0;
              txShift <= {readByte[6:0], 1'b0};
              serialDataLineOe <= ~readByte[7];
              state <= S_RD;
            end
          end
          default: begin
            state <= S_IDLE;
            serialDataLineOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // transmitter control, initialisation window and fault latch
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdnPrev <= 1'b1;
      initCnt <= 36'h000000000;
      initBusy <= 1'b1;
      sdnCnt <= 11'h000;
      resetMet <= 1'b0;
      faultLatched <= 1'b0;
      txFault <= 1'b1;
      txEnable <= 1'b0;
      modulePresenceLine <= 1'b0;
    end else begin
      sdnPrev <= sdn;
      modulePresenceLine <= 1'b0;
      if (initBusy) begin
        if (initCnt >= INIT_CYCLES - 36'h000000001) begin
          initBusy <= 1'b0;
        end
        initCnt <= initCnt + 36'h000000001;
      end
      if (sdn) begin
        if (sdnCnt >= RESET_CYC - 11'h001) begin
          resetMet <= 1'b1;
        end else begin
          sdnCnt <= sdnCnt + 11'h001;
        end
      end else begin
        sdnCnt <= 11'h000;
        resetMet <= 1'b0;
      end
      // a new fault cause wins over a clear in the same cycle
      faultLatched <= (faultCause & ~initBusy) |
        (faultLatched & ~(sdnPrev & ~sdn & resetMet));
      // raw cause covers the cycle in which the latch is still catching up at init end
      txFault <= faultLatched | initBusy | faultCause;
      txEnable <= ~sdn & ~initBusy & ~faultLatched & ~faultCause;
    end
  end
endmodule
`default_nettype wire

// >>> omm_mgmt_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module omm_mgmt_port_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic serialClockLine,
  input wire logic serialDataLineIn,
  input wire logic serialDataLineOut,
  input wire logic serialDataLineOe,
  input wire logic txShutdown,
  input wire logic txFaultCause,
  input wire logic txFault,
  input wire logic txEnable,
  input wire logic modulePresenceLine,
  input wire logic busIdle,
  input wire logic lowPower
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence startSeq;
    serialClockLine && $fell(serialDataLineIn) ##1 (serialClockLine && !serialDataLineIn) [*5];
  endsequence
  sequence stopSeq;
    serialClockLine && $rose(serialDataLineIn) ##1 (serialClockLine && serialDataLineIn) [*5];
  endsequence
  presence_grounded_a: assert property (!modulePresenceLine) else $error("presence not low");
  drive_low_a: assert property (!serialDataLineOut) else $error("data drive not low");
  idle_seen_a: assert property ((serialClockLine && serialDataLineIn) [*5] |-> busIdle)
    else $error("idle flag missing");
  start_wake_a: assert property (startSeq |-> !lowPower) else $error("start not seen");
  stop_sleep_a: assert property (stopSeq |-> lowPower) else $error("stop not seen");
  ack_clock_low_a: assert property ($changed(serialDataLineOe) |-> !serialClockLine)
    else $error("data drive changed in clock high");
  shut_off_a: assert property (txShutdown [*6] |-> !txEnable) else $error("not shut off");
  fault_shown_a: assert property (txFaultCause [*7] |-> txFault) else $error("fault not shown");
  fault_blocks_a: assert property (txFault [*2] |-> !txEnable) else $error("on during fault");
  tx_resume_a: assert property ((!txShutdown && !txFault && !txFaultCause) [*8] |-> txEnable)
    else $error("not resumed");
endmodule
bind omm_mgmt_port omm_mgmt_port_asserts i_omm_mgmt_port_asserts (.core_clk, .arst_n, .serialClockLine,
  .serialDataLineIn, .serialDataLineOut, .serialDataLineOe, .txShutdown, .txFaultCause, .txFault,
  .txEnable, .modulePresenceLine, .busIdle, .lowPower);
`default_nettype wire

// >>> omm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module omm_host_model (
  input wire logic core_clk,
  input wire logic sdaWire,
  output var logic sclPin,
  output var logic sdaLow
);
  initial begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end
  // set clock and data level, then hold for n core cycles; 16 cycles per bit
  task automatic drv(input logic c, input logic d, input int n);
    sclPin <= c;
    sdaLow <= !d;
    repeat (n) @(posedge core_clk);
  endtask
  // start or repeated start from an idle or low clock
  task automatic start();
    @(posedge core_clk);
    drv(1'b0, 1'b1, 4);
    drv(1'b1, 1'b1, 8);
    drv(1'b1, 1'b0, 8);
    drv(1'b0, 1'b0, 4);
  endtask
  // clock left high and data released afterwards
  task automatic stop();
    drv(1'b0, 1'b0, 4);
    drv(1'b1, 1'b0, 8);
    drv(1'b1, 1'b1, 8);
  endtask
  // nine bits, msb first; line sampled at the end of each high period
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      drv(1'b0, d[i], 4);
      drv(1'b1, d[i], 8);
      q[i] = sdaWire;
      drv(1'b0, d[i], 4);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_omm_mgmt_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_omm_mgmt_port;
  localparam logic [6:0] ADDR = 7'h50;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic txShutdown = 1'b0;
  logic txFaultCause = 1'b0;
  logic sdaOe, txFault, txEnable, presence, busIdle, lowPower, sclPin, sdaLow;
  logic [8:0] got;
  int nMismatch = 0;
  int testsRun = 0;
  wire sdaWire = !(sdaOe || sdaLow);
  always #5 core_clk = !core_clk;
  omm_host_model i_omm_host_model (.core_clk, .sdaWire, .sclPin, .sdaLow);
  omm_mgmt_port #(.DEV_ADDR(ADDR), .INIT_CYCLES(36'd50)) i_omm_mgmt_port (.core_clk, .arst_n,
    .serialClockLine(sclPin), .serialDataLineIn(sdaWire), .serialDataLineOut(), .serialDataLineOe(sdaOe),
    .txShutdown, .txFaultCause, .txFault, .txEnable, .modulePresenceLine(presence), .busIdle, .lowPower);
  task automatic finish_test();
    if (nMismatch == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] act, input logic [8:0] exp);
    testsRun++;
    if (act !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, act, exp);
    end
  endtask
  task automatic chkBit(input logic a, input logic e);
    chk({8'h00, a}, {8'h00, e});
  endtask
  // wait for fault (sel high) or enable to reach v; give up after lim cycles
  task automatic waitOut(input logic sel, input logic v, input int lim);
    for (int k = 0; k < lim && (sel ? txFault : txEnable) !== v; k++) @(negedge core_clk);
    chkBit(sel ? txFault : txEnable, v);
    if ((sel ? txFault : txEnable) !== v) finish_test();
  endtask
  task automatic testInit();
    chkBit(txFault, 1'b1);
    chkBit(presence, 1'b0);
    waitOut(1'b1, 1'b0, 80);
    waitOut(1'b0, 1'b1, 10);
  endtask
  task automatic testWrite();
    i_omm_host_model.start();
    chkBit(lowPower, 1'b0);
    i_omm_host_model.xbyte({ADDR, 2'b01}, got);
    chkBit(got[0], 1'b0);
    i_omm_host_model.xbyte(9'h00B, got);
    i_omm_host_model.xbyte(9'h14B, got);
    chkBit(got[0], 1'b0);
    i_omm_host_model.xbyte(9'h079, got);
    i_omm_host_model.stop();
    repeat (6) @(negedge core_clk);
    chkBit(lowPower, 1'b1);
    chkBit(busIdle, 1'b1);
  endtask
  task automatic testRead();
    i_omm_host_model.start();
    i_omm_host_model.xbyte({ADDR, 2'b01}, got);
    i_omm_host_model.xbyte(9'h00B, got);
    i_omm_host_model.start();
    i_omm_host_model.xbyte({ADDR, 2'b11}, got);
    chkBit(got[0], 1'b0);
    i_omm_host_model.xbyte(9'h1FE, got);
    chk(got, 9'h14A);
    i_omm_host_model.xbyte(9'h1FF, got);
    chk(got, 9'h079);
    i_omm_host_model.stop();
  endtask
  task automatic testWrongAddr();
    i_omm_host_model.start();
    i_omm_host_model.xbyte({7'h51, 2'b01}, got);
    chkBit(got[0], 1'b1);
    i_omm_host_model.stop();
  endtask
  task automatic testShutdown();
    @(posedge core_clk) txShutdown <= 1'b1;
    waitOut(1'b0, 1'b0, 1000);
    @(posedge core_clk) txShutdown <= 1'b0;
    waitOut(1'b0, 1'b1, 1000);
  endtask
  task automatic testFault();
    @(posedge core_clk) txFaultCause <= 1'b1;
    waitOut(1'b1, 1'b1, 10);
    chkBit(txEnable, 1'b0);
    @(posedge core_clk) txFaultCause <= 1'b0;
    @(posedge core_clk) txShutdown <= 1'b1;
    repeat (500) @(posedge core_clk);
    txShutdown <= 1'b0;
    repeat (20) @(negedge core_clk);
    chkBit(txFault, 1'b1);
    i_omm_host_model.start();
    i_omm_host_model.xbyte({ADDR, 2'b01}, got);
    i_omm_host_model.xbyte(9'h001, got);
    i_omm_host_model.start();
    i_omm_host_model.xbyte({ADDR, 2'b11}, got);
    i_omm_host_model.xbyte(9'h1FF, got);
    chk(got, 9'h007);
    i_omm_host_model.stop();
    @(posedge core_clk) txShutdown <= 1'b1;
    repeat (1010) @(posedge core_clk);
    txShutdown <= 1'b0;
    waitOut(1'b1, 1'b0, 10);
    waitOut(1'b0, 1'b1, 10);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge core_clk);
    testInit();
    testWrite();
    testRead();
    testWrongAddr();
    testShutdown();
    testFault();
    finish_test();
  end
endmodule
`default_nettype wire
